// ### hdl/switching_clock_sync_control.v
// Phase clock pin role detection, lock, loss detection and restart
//
// Functional notes
// - Free-running clock from 200 kHz to 1 MHz
// - Lock to external clock within twenty percent
// - Edges or high level: pin input, rising
// - Nothing seen: pin output, drive own clock
// - Output clock has equal high, low time at even period
// - Loop slave: always input, falling edges
// - Pin role fixed until power cycle
// - Force bits override; force-input wins; default clear
// - Stop switching when expected clock missing
// - Live clock loss bit at 80h
// - Clock loss raises no bus alert
// - Ten microsecond detection; slave runs slow meanwhile
// - Never-present clock keeps switching off while disable bit clear
// - Seven cycles after return, then soft-start
// - Disable bit: no flag, no stop
`timescale 1ns/1ns
`include "sync_ctrl_defines.vh"

module switching_clock_sync_control (
  // Clock and power-cycle reset
  input  wire       clk,
  input  wire       rst,
  // Phase clock pin
  input  wire       phaseClkIn,
  output wire       phaseClkOut,
  output wire       phaseClkOe,
  // Straps and stored options
  input  wire       loopSlaveStrap,
  input  wire       forceClockInput,
  input  wire       forceClockOutput,
  input  wire [9:0] freqSetResistorPeriod,
  // Register port
  input  wire [7:0] regAddr,
  input  wire       regWrEn,
  input  wire [7:0] regWrData,
  input  wire       regRdEn,
  output wire [7:0] regRdData,
  // Power stage control
  output wire       switchTick,
  output wire       switchEnable,
  output wire       softStartStart,
  output wire       clockIsInput
);

  localparam [2:0] ST_DETECT  = 3'h0;
  localparam [2:0] ST_WAIT    = 3'h1;
  localparam [2:0] ST_RESTORE = 3'h2;
  localparam [2:0] ST_RUN     = 3'h3;
  localparam [2:0] ST_FREE    = 3'h4;
  localparam [2:0] ST_OUT     = 3'h5;
  localparam [11:0] LOSS_LIM   = `LOSS_CYC;
  localparam [11:0] DETECT_LIM = `DETECT_CYC;
  localparam [9:0]  PER_MIN    = `PERIOD_MIN_CYC;
  localparam [9:0]  PER_MAX    = `PERIOD_MAX_CYC;
  localparam [2:0]  EDGES_LIM  = `RESTORE_EDGES;
  localparam [12:0] SLOW_MUL   = `SLOW_NUM;
  localparam [12:0] SLOW_DIV   = `SLOW_DEN;
  // Register address match
  function addrIs;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addrIs = (addr == offset);
    end
  endfunction

  // Pin synchronisers
  reg         pinSync1_ff;
  reg         pinSync2_ff;
  reg         pinPrev_ff;
  reg         slaveSync1_ff;
  reg         slaveSync2_ff;

  // Role detection
  reg  [11:0] detCnt_ff;
  reg         edgeSeen_ff;
  reg         roleInput_ff;
  reg         loopSlave_ff;

  // Loss and restart
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [11:0] gapCnt_ff;
  reg  [2:0]  restoreCnt_ff;
  reg  [2:0]  nxt_restoreCnt;

  // Registers
  reg  [7:0]  config_ff;
  reg         faultFlag_ff;
  reg  [7:0]  regRdData_ff;
  reg  [7:0]  nxt_rdData;

  // Outputs
  reg         phaseClkOut_ff;
  reg         phaseClkOe_ff;
  reg         switchTick_ff;
  reg         nxt_tick;
  reg         switchEnable_ff;
  reg         nxt_enable;
  reg         softStart_ff;
  reg         nxt_softStart;
  reg         clockIsInput_ff;

  wire        riseEdge;
  wire        fallEdge;
  wire        anyEdge;
  wire        qualEdge;
  wire        lostNow;
  wire        lossDis;
  wire        detectEnd;
  wire        autoInput;
  wire        decideInput;
  wire [9:0]  basePeriod;
  wire [12:0] slowProd;
  wire [12:0] slowQuot;
  wire [10:0] oscPeriod;
  wire        oscSlow;
  wire        oscRestart;
  wire        oscTick;
  wire        oscLevel;
  assign riseEdge = pinSync2_ff & ~pinPrev_ff;
  assign fallEdge = ~pinSync2_ff & pinPrev_ff;
  assign anyEdge  = riseEdge | fallEdge;
  assign qualEdge = roleInput_ff & (loopSlave_ff ? fallEdge : riseEdge);
  assign lostNow  = (gapCnt_ff == LOSS_LIM);
  assign lossDis  = config_ff[`CFG_LOSS_DIS_BIT];
  assign detectEnd = (state_ff == ST_DETECT) && (detCnt_ff == DETECT_LIM);

  // Role decision at the end of the power-up window
  assign autoInput   = edgeSeen_ff | anyEdge | pinSync2_ff;
  assign decideInput = slaveSync2_ff | forceClockInput |
                       (~forceClockOutput & autoInput);

  // Oscillator period from the timing setting, clamped to range
  assign basePeriod = (freqSetResistorPeriod < PER_MIN) ? PER_MIN :
                      (freqSetResistorPeriod > PER_MAX) ? PER_MAX :
                      freqSetResistorPeriod;
  assign slowProd   = {3'h0, basePeriod} * SLOW_MUL;
  assign slowQuot   = slowProd / SLOW_DIV;
  assign oscSlow    = roleInput_ff & (state_ff == ST_RUN);
  assign oscPeriod  = oscSlow ? slowQuot[10:0] : {1'b0, basePeriod};
  assign oscRestart = qualEdge;

  free_run_osc osc (
    .clk     (clk),
    .rst     (rst),
    .period  (oscPeriod),
    .restart (oscRestart),
    .tick    (oscTick),
    .level   (oscLevel)
  );

  // Two-stage synchronisers and edge history
  always @(posedge clk) begin
    if (rst) begin
      pinSync1_ff   <= 1'b0;
      pinSync2_ff   <= 1'b0;
      pinPrev_ff    <= 1'b0;
      slaveSync1_ff <= 1'b0;
      slaveSync2_ff <= 1'b0;
    end else begin
      pinSync1_ff   <= phaseClkIn;
      pinSync2_ff   <= pinSync1_ff;
      pinPrev_ff    <= pinSync2_ff;
      slaveSync1_ff <= loopSlaveStrap;
      slaveSync2_ff <= slaveSync1_ff;
    end
  end

  // Power-up detection, role held until reset
  always @(posedge clk) begin
    if (rst) begin
      detCnt_ff    <= 12'h000;
      edgeSeen_ff  <= 1'b0;
      roleInput_ff <= 1'b0;
      loopSlave_ff <= 1'b0;
    end else if (state_ff == ST_DETECT) begin
      detCnt_ff   <= detCnt_ff + 12'h001;
      edgeSeen_ff <= edgeSeen_ff | anyEdge;
      if (detectEnd) begin
        roleInput_ff <= decideInput;
        loopSlave_ff <= slaveSync2_ff;
      end
    end
  end

  // Gap timeout, restarted by each qualifying edge
  always @(posedge clk) begin
    if (rst) begin
      gapCnt_ff <= 12'h000;
    end else if (qualEdge) begin
      gapCnt_ff <= 12'h000;
    end else if (!lostNow) begin
      gapCnt_ff <= gapCnt_ff + 12'h001;
    end
  end

  // Next state and power stage control
  always @* begin
    nxt_state      = state_ff;
    nxt_restoreCnt = restoreCnt_ff;
    nxt_tick       = 1'b0;
    nxt_enable     = 1'b0;
    nxt_softStart  = 1'b0;
    case (state_ff)
      ST_DETECT: begin
        if (detectEnd) begin
          if (decideInput) begin
            nxt_state = ST_WAIT;
          end else begin
            nxt_state     = ST_OUT;
            nxt_softStart = 1'b1;
            nxt_enable    = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (lossDis) begin
          nxt_state = ST_FREE;
        end else if (qualEdge) begin
          nxt_state      = ST_RESTORE;
          nxt_restoreCnt = 3'h1;
        end
      end
      ST_RESTORE: begin
        if (lostNow) begin
          nxt_state = ST_WAIT;
        end else if (qualEdge) begin
          if (restoreCnt_ff == (EDGES_LIM - 3'h1)) begin
            nxt_state     = ST_RUN;
            nxt_softStart = 1'b1;
            nxt_tick      = 1'b1;
            nxt_enable    = 1'b1;
          end else begin
            nxt_restoreCnt = restoreCnt_ff + 3'h1;
          end
        end
      end
      ST_RUN: begin
        nxt_enable = 1'b1;
        nxt_tick   = qualEdge | oscTick;
        if (lostNow) begin
          if (lossDis) begin
            nxt_state = ST_FREE;
          end else begin
            nxt_state  = ST_WAIT;
            nxt_enable = 1'b0;
            nxt_tick   = 1'b0;
          end
        end
      end
      ST_FREE: begin
        nxt_enable = 1'b1;
        nxt_tick   = oscTick;
        if (qualEdge) begin
          nxt_state = ST_RUN;
          nxt_tick  = 1'b1;
        end else if (!lossDis) begin
          nxt_state  = ST_WAIT;
          nxt_enable = 1'b0;
          nxt_tick   = 1'b0;
        end
      end
      ST_OUT: begin
        nxt_enable = 1'b1;
        nxt_tick   = oscTick;
      end
      default: begin
        nxt_state = ST_DETECT;
      end
    endcase
  end

  // State and output flops
  always @(posedge clk) begin
    if (rst) begin
      state_ff        <= ST_DETECT;
      restoreCnt_ff   <= 3'h0;
      switchTick_ff   <= 1'b0;
      switchEnable_ff <= 1'b0;
      softStart_ff    <= 1'b0;
      phaseClkOut_ff  <= 1'b0;
      phaseClkOe_ff   <= 1'b0;
      clockIsInput_ff <= 1'b0;
      faultFlag_ff    <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      restoreCnt_ff   <= nxt_restoreCnt;
      switchTick_ff   <= nxt_tick;
      switchEnable_ff <= nxt_enable;
      softStart_ff    <= nxt_softStart;
      phaseClkOe_ff   <= (nxt_state == ST_OUT);
      phaseClkOut_ff  <= (nxt_state == ST_OUT) & oscLevel;
      clockIsInput_ff <= roleInput_ff;
      // Live flag, no alert is raised from it
      faultFlag_ff    <= (nxt_state == ST_WAIT) & ~lossDis;
    end
  end

  // Register write
  always @(posedge clk) begin
    if (rst) begin
      config_ff <= `CFG_RESET;
    end else if (regWrEn && addrIs(regAddr, `REG_MISC_CONFIG)) begin
      config_ff <= regWrData;
    end
  end

  // Register read
  always @* begin
    nxt_rdData = 8'h00;
    if (addrIs(regAddr, `REG_MFR_STATUS)) begin
      nxt_rdData = `STAT_RESET;
      nxt_rdData[`STAT_CLK_LOSS_BIT] = faultFlag_ff;
    end else if (addrIs(regAddr, `REG_MISC_CONFIG)) begin
      nxt_rdData = config_ff;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      regRdData_ff <= 8'h00;
    end else if (regRdEn) begin
      regRdData_ff <= nxt_rdData;
    end
  end

  assign phaseClkOut    = phaseClkOut_ff;
  assign phaseClkOe     = phaseClkOe_ff;
  assign regRdData      = regRdData_ff;
  assign switchTick     = switchTick_ff;
  assign switchEnable   = switchEnable_ff;
  assign softStartStart = softStart_ff;
  assign clockIsInput   = clockIsInput_ff;
endmodule // switching_clock_sync_control

// ### hdl/sync_ctrl_defines.vh
// Constants for the switching clock synchronisation block
`ifndef SYNC_CTRL_DEFINES_VH
`define SYNC_CTRL_DEFINES_VH

// Register offsets
`define REG_MFR_STATUS    8'h80
`define REG_MISC_CONFIG   8'hF0

// Field positions
`define STAT_CLK_LOSS_BIT 0
`define CFG_LOSS_DIS_BIT  0

// Reset values
`define CFG_RESET         8'h00
`define STAT_RESET        8'h00

// System clock
`define CLK_PERIOD_NS     8
`define CLK_FREQ_KHZ      125000

// Switching frequency range
`define FSW_MIN_KHZ       200
`define FSW_MAX_KHZ       1000
`define PERIOD_MIN_CYC    10'h07D
`define PERIOD_MAX_CYC    10'h271

// Slave fallback runs about 40 percent slow: period times 5/3
`define SLOW_NUM          13'h0005
`define SLOW_DEN          13'h0003

// Clock loss timeout, longest time, rounded down
`define LOSS_TIME_NS      10000
`define LOSS_CYC          12'h4E2

// Power-up role detection window
`define DETECT_TIME_NS    20000
`define DETECT_CYC        12'h9C4

// Edges counted after clock return
`define RESTORE_EDGES     3'h7

`endif

// ### hdl/free_run_osc.v
// Free-running switching oscillator with equal high and low time for even periods
`timescale 1ns/1ns

module free_run_osc (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Control
  input  wire [10:0] period,
  input  wire        restart,
  // Outputs
  output wire        tick,
  output wire        level
);

  reg  [10:0] cnt_ff;
  reg         tick_ff;
  reg         level_ff;
  wire        wrap;
  wire [10:0] halfPeriod;

  assign wrap       = (cnt_ff >= (period - 11'h001));
  assign halfPeriod = {1'b0, period[10:1]};
  assign tick       = tick_ff;
  assign level      = level_ff;

  // Period counter, realigned by restart
  always @(posedge clk) begin
    if (rst) begin
      cnt_ff   <= 11'h000;
      tick_ff  <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      if (restart || wrap) begin
        cnt_ff <= 11'h000;
      end else begin
        cnt_ff <= cnt_ff + 11'h001;
      end
      tick_ff  <= wrap & ~restart;
      level_ff <= (cnt_ff < halfPeriod);
    end
  end

endmodule // free_run_osc

// ### verification/switching_clock_sync_control_sva.sv
// Concurrent checks on pin role, switching control and loss timing
`timescale 1ns/1ns

module sync_control_checker (
  // Clock and reset
  input wire       clk,
  input wire       rst,
  // Pin and straps
  input wire       phaseClkIn,
  input wire       phaseClkOut,
  input wire       phaseClkOe,
  input wire       loopSlaveStrap,
  input wire [9:0] freqSetResistorPeriod,
  // Power stage control
  input wire       switchTick,
  input wire       switchEnable,
  input wire       softStartStart,
  input wire       clockIsInput
);
  reg        pinPrev_ff;
  reg [11:0] gapCnt_ff;
  reg [3:0]  edgeCnt_ff;
  reg [9:0]  highCnt_ff;
  wire       qualEdge;

  assign qualEdge = loopSlaveStrap ? (pinPrev_ff & ~phaseClkIn) : (~pinPrev_ff & phaseClkIn);

  // Gap since qualifying edge, edges while off, high run length
  always @(posedge clk) begin
    pinPrev_ff <= phaseClkIn;
    gapCnt_ff  <= (rst | qualEdge) ? 12'h000 : gapCnt_ff + {11'h000, ~&gapCnt_ff};
    edgeCnt_ff <= (switchEnable | ~clockIsInput) ? 4'h0 : edgeCnt_ff + {3'h0, qualEdge};
    highCnt_ff <= phaseClkOut ? highCnt_ff + 10'h001 : 10'h000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  reset_clears_a: assert property (disable iff (1'b0)
    $fell(rst) |-> !switchEnable && !phaseClkOe && !clockIsInput) else $error("reset left outputs set");
  role_fixed_a: assert property (
    $fell(clockIsInput) || $fell(phaseClkOe) |-> $past(rst)) else $error("role changed");
  oe_role_a: assert property (phaseClkOe |-> !clockIsInput) else $error("drive in input role");
  idle_low_a: assert property (!phaseClkOe |-> !phaseClkOut) else $error("pin value not low");
  half_duty_a: assert property ($fell(phaseClkOut) && phaseClkOe |->
    highCnt_ff == freqSetResistorPeriod[9:1]) else $error("high time not half period");
  tick_enabled_a: assert property (switchTick |-> switchEnable) else $error("tick while off");
  start_pulse_a: assert property (softStartStart |-> switchEnable ##1 !softStartStart)
    else $error("soft start pulse wrong");
  restore_count_a: assert property (softStartStart && clockIsInput |->
    edgeCnt_ff >= 4'h6 && edgeCnt_ff <= 4'h7) else $error("restart edge count wrong");
  loss_latency_a: assert property ($fell(switchEnable) && clockIsInput |->
    gapCnt_ff >= 12'd1246 && gapCnt_ff <= 12'd1260) else $error("loss timeout wrong");

  cover property (softStartStart && clockIsInput);
  cover property ($fell(switchEnable) && clockIsInput);
  cover property ($fell(phaseClkOut) && phaseClkOe);
endmodule // sync_control_checker

bind switching_clock_sync_control sync_control_checker i_chk (.clk(clk), .rst(rst),
  .phaseClkIn(phaseClkIn), .phaseClkOut(phaseClkOut), .phaseClkOe(phaseClkOe),
  .loopSlaveStrap(loopSlaveStrap), .freqSetResistorPeriod(freqSetResistorPeriod),
  .switchTick(switchTick), .switchEnable(switchEnable), .softStartStart(softStartStart),
  .clockIsInput(clockIsInput));

// ### verification/clock_source_model.sv
// Behavioural external clock source for the phase clock pin
`timescale 1ns/1ns

module clock_source_model (
  // Control
  input  wire run,
  input  wire tieHigh,
  // Pin drive
  output reg  level
);
  // Symmetric 160 ns clock, parked at the rail level when stopped
  initial begin
    level = 1'b0;
    #3;
    forever begin
      #80;
      level = run ? ~level : tieHigh;
    end
  end
endmodule // clock_source_model

// ### verification/switching_clock_sync_control_tb.sv
// Self-checking bench for the switching clock synchronisation block
`timescale 1ns/1ns

module switching_clock_sync_control_tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       strap = 1'b0, fIn = 1'b0, fOut = 1'b0, srcRun = 1'b0, srcHigh = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rd;
  logic       regWrEn = 1'b0, regRdEn = 1'b0, ok;
  wire  [7:0] regRdData;
  wire        phaseClkOut, phaseClkOe, srcLevel, switchTick, switchEnable;
  wire        softStartStart, clockIsInput;
  wire        pinLevel = phaseClkOe ? phaseClkOut : srcLevel;
  int         err_count = 0;
  int         num_checks = 0;
  int         n;
  // Row: strap, force in, force out, run, tied high, then input role, oe, enable
  logic [7:0] rows [8] = '{8'h03, 8'h15, 8'h0C, 8'h84, 8'h95, 8'h64, 8'h23, 8'h44};

  always #4 clk = ~clk;

  clock_source_model i_src (.run(srcRun), .tieHigh(srcHigh), .level(srcLevel));
  switching_clock_sync_control i_dut (.clk(clk), .rst(rst), .phaseClkIn(pinLevel),
    .phaseClkOut(phaseClkOut), .phaseClkOe(phaseClkOe), .loopSlaveStrap(strap),
    .forceClockInput(fIn), .forceClockOutput(fOut), .freqSetResistorPeriod(10'h07E),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .switchTick(switchTick), .switchEnable(switchEnable),
    .softStartStart(softStartStart), .clockIsInput(clockIsInput));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    regAddr = a;
    regRdEn = 1'b1;
    tick(1);
    regRdEn = 1'b0;
    d = regRdData;
  endtask

  task automatic countTicks(input int k, output int c);
    c = 0;
    repeat (k) begin
      tick(1);
      if (switchTick === 1'b1)
        c++;
    end
  endtask

  task automatic waitStart(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 300 && !seen; i++) begin
      tick(1);
      seen = (softStartStart === 1'b1);
    end
  endtask

  initial begin
    for (int r = 0; r < 8; r++) begin
      {strap, fIn, fOut, srcRun, srcHigh} = rows[r][7:3];
      rst = 1'b1;
      tick(16);
      rst = 1'b0;
      check("cleared", {clockIsInput, phaseClkOe, switchEnable}, 8'h00);
      tick(2700);
      check("role", {clockIsInput, phaseClkOe, switchEnable}, rows[r][2:0]);
    end
    regRead(8'h80, rd);
    check("flag waiting", rd, 8'h01);
    regRead(8'hF0, rd);
    check("config reset", rd, 8'h00);
    regWrite(8'h80, 8'hFF);
    regWrite(8'hF0, 8'hA4);
    regRead(8'h80, rd);
    check("status read only", rd, 8'h01);
    regRead(8'hF0, rd);
    check("config stored", rd, 8'hA4);
    regRead(8'h33, rd);
    check("unmapped", rd, 8'h00);
    srcRun = 1'b1;
    waitStart(ok);
    check("first start", ok, 1'b1);
    countTicks(200, n);
    check("ticks per edge", n[7:0], 8'h0A);
    regRead(8'h80, rd);
    check("flag live", rd, 8'h00);
    srcRun = 1'b0;
    countTicks(1200, n);
    check("on before timeout", switchEnable, 1'b1);
    check("slow ticks", n >= 4 && n <= 6, 1'b1);
    tick(100);
    check("stop on loss", switchEnable, 1'b0);
    check("role kept", clockIsInput, 1'b1);
    regRead(8'h80, rd);
    check("flag on loss", rd, 8'h01);
    srcRun = 1'b1;
    waitStart(ok);
    check("restart", ok, 1'b1);
    regWrite(8'hF0, 8'h01);
    srcRun = 1'b0;
    tick(1400);
    check("no stop disabled", switchEnable, 1'b1);
    countTicks(630, n);
    check("free ticks", n[7:0], 8'h05);
    regRead(8'h80, rd);
    check("flag suppressed", rd, 8'h00);
    results();
  end

  initial begin
    #400000;
    err_count++;
    results();
  end
endmodule // switching_clock_sync_control_tb
